// ===== hdl/cirq_router.sv
// central interrupt router: 32 request channels onto normal and fast lines
// assumes requests come from logic on core_clk; plain register port
//
// Strobed register access is this design's own decision.
`default_nettype none
// How it works
// (R1) every register 32 bits, word aligned
// (R2) writes update only enabled byte lanes
// (R3) reads allowed in user and privileged mode
// (R4) user writes to mask/routing trap, ignored
// (R5) normal line index in bits 7..0
// (R6) higher channel number wins priority
// (R7) index zero idle, else channel plus one
// (R8) fast line index, same order, encoding
// (R9) routing bit: 0 normal, 1 fast
// (R10) routing clears to normal at reset
// (R11) channels 31..24 fault, serial, pwm, converter
// (R12) channels 23..16 clock, wide timer, narrow timer
// (R13) channels 15..8 timers, front ends, buses, serial
// (R14) channels 7..0 serial, watchdog, external, brownout
// (R15) read-only pending register, one per channel
// (R16) line index over pending, enabled, routed channels
// (R17) channel number equals bit in every register
module cirq_router (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [35:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic [3:0] wr_be,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic priv_mode,
   output logic [31:0] rd_data,
   output logic illegal_access,
   output logic normal_irq,
   output logic fast_irq,
   output logic irq_any,
   input wire logic external_fault_req,
   input wire logic system_serial_req,
   input wire logic pwm_gen0_req,
   input wire logic pwm_gen1_req,
   input wire logic pwm_gen2_req,
   input wire logic pwm_gen3_req,
   input wire logic fault_mux_req,
   input wire logic converter_req,
   input wire logic current_ctrl_clock_req,
   input wire logic wide_timer_cmp0_req,
   input wire logic wide_timer_cap0_req,
   input wire logic wide_timer_cmp1_req,
   input wire logic wide_timer_cap1_deadtime_req,
   input wire logic wide_timer_overflow_req,
   input wire logic narrow_timer_pwm0_req,
   input wire logic narrow_timer_pwm1_req,
   input wire logic narrow_timer_pwm2_req,
   input wire logic narrow_timer_pwm3_req,
   input wire logic front_end2_req,
   input wire logic front_end1_req,
   input wire logic front_end0_req,
   input wire logic comparator_serial_req,
   input wire logic pmbus_req,
   input wire logic serial1_tx_req,
   input wire logic serial1_rx_req,
   input wire logic serial0_tx_req,
   input wire logic serial0_rx_req,
   input wire logic serial_err_req,
   input wire logic watchdog_half_req,
   input wire logic watchdog_max_req,
   input wire logic external_pin_req,
   input wire logic brownout_req
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [31:0] irq_type_routing;
   logic [31:0] request_mask;
   logic [31:0] pending_requests;
   logic [7:0] normal_irq_index;
   logic [7:0] fast_irq_index;
   logic [31:0] req_vec;
   logic [31:0] lane_mask;
   logic [31:0] active;
   logic [31:0] normal_req;
   logic [31:0] fast_req;
   logic [7:0] next_normal_index;
   logic [7:0] next_fast_index;
   logic [31:0] next_rd_data;
   logic [31:0] clear_bits;
   logic sel_routing;
   logic sel_mask;
   logic sel_clear;
   logic protected_wr;

   // ------------------------------------------------------------
   // channel gathering
   // ------------------------------------------------------------
   always_comb begin
      req_vec = cirq_pkg::PENDING_RESET;
      req_vec[cirq_pkg::CH_EXT_FAULT] = external_fault_req; // see (R11)
      req_vec[cirq_pkg::CH_SYS_SERIAL] = system_serial_req; // see (R11)
      req_vec[cirq_pkg::CH_PWM_GEN0] = pwm_gen0_req; // see (R11)
      req_vec[cirq_pkg::CH_PWM_GEN1] = pwm_gen1_req; // see (R11)
      req_vec[cirq_pkg::CH_PWM_GEN2] = pwm_gen2_req; // see (R11)
      req_vec[cirq_pkg::CH_PWM_GEN3] = pwm_gen3_req; // see (R11)
      req_vec[cirq_pkg::CH_FAULT_MUX] = fault_mux_req; // see (R11)
      req_vec[cirq_pkg::CH_CONVERTER] = converter_req; // see (R11)
      // see (R12)
      req_vec[cirq_pkg::CH_CUR_CTRL_CLOCK] = current_ctrl_clock_req;
      req_vec[cirq_pkg::CH_WT_CMP0] = wide_timer_cmp0_req; // see (R12)
      req_vec[cirq_pkg::CH_WT_CAP0] = wide_timer_cap0_req; // see (R12)
      req_vec[cirq_pkg::CH_WT_CMP1] = wide_timer_cmp1_req; // see (R12)
      // see (R12)
      req_vec[cirq_pkg::CH_WT_CAP1_DT] = wide_timer_cap1_deadtime_req;
      req_vec[cirq_pkg::CH_WT_OVF] = wide_timer_overflow_req; // see (R12)
      req_vec[cirq_pkg::CH_NT_PWM0] = narrow_timer_pwm0_req; // see (R12)
      req_vec[cirq_pkg::CH_NT_PWM1] = narrow_timer_pwm1_req; // see (R12)
      req_vec[cirq_pkg::CH_NT_PWM2] = narrow_timer_pwm2_req; // see (R13)
      req_vec[cirq_pkg::CH_NT_PWM3] = narrow_timer_pwm3_req; // see (R13)
      req_vec[cirq_pkg::CH_FRONT_END2] = front_end2_req; // see (R13)
      req_vec[cirq_pkg::CH_FRONT_END1] = front_end1_req; // see (R13)
      req_vec[cirq_pkg::CH_FRONT_END0] = front_end0_req; // see (R13)
      req_vec[cirq_pkg::CH_CMP_SERIAL] = comparator_serial_req; // see (R13)
      req_vec[cirq_pkg::CH_PMBUS] = pmbus_req; // see (R13)
      req_vec[cirq_pkg::CH_SER1_TX] = serial1_tx_req; // see (R13)
      req_vec[cirq_pkg::CH_SER1_RX] = serial1_rx_req; // see (R14)
      req_vec[cirq_pkg::CH_SER0_TX] = serial0_tx_req; // see (R14)
      req_vec[cirq_pkg::CH_SER0_RX] = serial0_rx_req; // see (R14)
      req_vec[cirq_pkg::CH_SER_ERR] = serial_err_req; // see (R14)
      req_vec[cirq_pkg::CH_WD_HALF] = watchdog_half_req; // see (R14)
      req_vec[cirq_pkg::CH_WD_MAX] = watchdog_max_req; // see (R14)
      req_vec[cirq_pkg::CH_EXT_PIN] = external_pin_req; // see (R14)
      req_vec[cirq_pkg::CH_BROWNOUT] = brownout_req; // see (R14)
   end

   // ------------------------------------------------------------
   // write decode
   // ------------------------------------------------------------
   always_comb begin
      for (int l = 0; l < cirq_pkg::LANES; l++) begin
         lane_mask[l*cirq_pkg::LANE_W +: cirq_pkg::LANE_W] =
            {cirq_pkg::LANE_W{wr_be[l]}}; // see (R2)
      end
   end

   // only full-word addresses decode, so lanes never alias
   assign sel_routing = (addr == cirq_pkg::IRQ_TYPE_ROUTING_ADDR); // see (R1)
   assign sel_mask = (addr == cirq_pkg::REQUEST_MASK_ADDR);
   assign sel_clear = (addr == cirq_pkg::PENDING_CLEAR_ADDR);
   assign protected_wr = wr_stb && (sel_routing || sel_mask);
   assign clear_bits = (wr_stb && sel_clear) ? (wr_data & lane_mask)
                                              : cirq_pkg::PENDING_RESET;

   // ------------------------------------------------------------
   // routing register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq_type_routing <= cirq_pkg::ROUTING_RESET; // see (R10)
      end else if (wr_stb && sel_routing && priv_mode) begin // see (R4)
         irq_type_routing <= (irq_type_routing & ~lane_mask)
                           | (wr_data & lane_mask); // see (R2)
      end
   end

   // ------------------------------------------------------------
   // mask register, 1 lets a channel reach its line
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         request_mask <= cirq_pkg::MASK_RESET;
      end else if (wr_stb && sel_mask && priv_mode) begin // see (R4)
         request_mask <= (request_mask & ~lane_mask)
                       | (wr_data & lane_mask); // see (R2)
      end
   end

   // ------------------------------------------------------------
   // illegal access exception
   // ------------------------------------------------------------
   // user-mode writes to routing or mask are dropped and flagged for one cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         illegal_access <= 1'b0;
      end else begin
         illegal_access <= protected_wr && !priv_mode; // see (R4)
      end
   end

   // ------------------------------------------------------------
   // pending requests, sticky
   // ------------------------------------------------------------
   // a request in the clearing cycle survives: set beats clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pending_requests <= cirq_pkg::PENDING_RESET;
      end else begin
         pending_requests <= (pending_requests & ~clear_bits)
                           | req_vec; // see (R15) (R17)
      end
   end

   // ------------------------------------------------------------
   // line selection and priority
   // ------------------------------------------------------------
   assign active = pending_requests & request_mask; // see (R16)
   assign normal_req = active & ~irq_type_routing; // see (R9) (R17)
   assign fast_req = active & irq_type_routing; // see (R9) (R17)

   cirq_prio_enc u_normal_enc (
      .req(normal_req),
      .index(next_normal_index)
   ); // see (R6) (R7)

   cirq_prio_enc u_fast_enc (
      .req(fast_req),
      .index(next_fast_index)
   ); // see (R6) (R7) (R8)

   // index and line flops move together, one cycle behind pending
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         normal_irq_index <= cirq_pkg::INDEX_NONE; // see (R7)
         fast_irq_index <= cirq_pkg::INDEX_NONE;
         normal_irq <= 1'b0;
         fast_irq <= 1'b0;
      end else begin
         normal_irq_index <= next_normal_index; // see (R5)
         fast_irq_index <= next_fast_index; // see (R8)
         normal_irq <= next_normal_index != cirq_pkg::INDEX_NONE; // see (R16)
         fast_irq <= next_fast_index != cirq_pkg::INDEX_NONE; // see (R16)
      end
   end

   // ------------------------------------------------------------
   // summary interrupt
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq_any <= 1'b0;
      end else begin
         irq_any <= |active;
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   // reads ignore privilege; unmapped reads return zero
   always_comb begin
      next_rd_data = cirq_pkg::READ_ZERO;
      if (rd_stb) begin // see (R3)
         case (addr)
            cirq_pkg::NORMAL_IRQ_INDEX_ADDR: begin
               next_rd_data = {24'h000000, normal_irq_index}; // see (R5)
            end
            cirq_pkg::FAST_IRQ_INDEX_ADDR: begin
               next_rd_data = {24'h000000, fast_irq_index}; // see (R8)
            end
            cirq_pkg::IRQ_TYPE_ROUTING_ADDR: begin
               next_rd_data = irq_type_routing;
            end
            cirq_pkg::PENDING_REQUESTS_ADDR: begin
               next_rd_data = pending_requests; // see (R15)
            end
            cirq_pkg::PENDING_CLEAR_ADDR: begin
               next_rd_data = pending_requests;
            end
            cirq_pkg::REQUEST_MASK_ADDR: begin
               next_rd_data = request_mask;
            end
            default: begin
               next_rd_data = cirq_pkg::READ_ZERO;
            end
         endcase
      end
   end

   // data stand only in the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rd_data <= cirq_pkg::READ_ZERO;
      end else begin
         rd_data <= next_rd_data; // see (R1)
      end
   end
endmodule
`default_nettype wire

// ===== pkg/cirq_pkg.sv
// constants of the central interrupt router: map, fields, channel numbers
// assumes a 36-bit byte address and 32-bit registers on a plain port
`default_nettype none
package cirq_pkg;
   // ------------------------------------------------------------
   // bus geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 36;
   localparam int DATA_W = 32;
   localparam int LANES = 4;
   localparam int LANE_W = 8;
   localparam int NUM_CH = 32;
   localparam int IDX_W = 8;

   // ------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [35:0] NORMAL_IRQ_INDEX_ADDR = 36'hFFFFFFF20;
   localparam logic [35:0] FAST_IRQ_INDEX_ADDR = 36'hFFFFFFF24;
   localparam logic [35:0] IRQ_TYPE_ROUTING_ADDR = 36'hFFFFFFF2C;
   localparam logic [35:0] PENDING_REQUESTS_ADDR = 36'hFFFFFFF30;
   localparam logic [35:0] REQUEST_MASK_ADDR = 36'hFFFFFFF34;
   localparam logic [35:0] PENDING_CLEAR_ADDR = 36'hFFFFFFF38;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [31:0] ROUTING_RESET = 32'h00000000;
   localparam logic [31:0] MASK_RESET = 32'h00000000;
   localparam logic [31:0] PENDING_RESET = 32'h00000000;
   localparam logic [7:0] INDEX_NONE = 8'h00;
   localparam logic [31:0] READ_ZERO = 32'h00000000;

   // ------------------------------------------------------------
   // channel numbers, also the bit position in every register
   // ------------------------------------------------------------
   localparam int CH_EXT_FAULT = 31;
   localparam int CH_SYS_SERIAL = 30;
   localparam int CH_PWM_GEN0 = 29;
   localparam int CH_PWM_GEN1 = 28;
   localparam int CH_PWM_GEN2 = 27;
   localparam int CH_PWM_GEN3 = 26;
   localparam int CH_FAULT_MUX = 25;
   localparam int CH_CONVERTER = 24;
   localparam int CH_CUR_CTRL_CLOCK = 23;
   localparam int CH_WT_CMP0 = 22;
   localparam int CH_WT_CAP0 = 21;
   localparam int CH_WT_CMP1 = 20;
   localparam int CH_WT_CAP1_DT = 19;
   localparam int CH_WT_OVF = 18;
   localparam int CH_NT_PWM0 = 17;
   localparam int CH_NT_PWM1 = 16;
   localparam int CH_NT_PWM2 = 15;
   localparam int CH_NT_PWM3 = 14;
   localparam int CH_FRONT_END2 = 13;
   localparam int CH_FRONT_END1 = 12;
   localparam int CH_FRONT_END0 = 11;
   localparam int CH_CMP_SERIAL = 10;
   localparam int CH_PMBUS = 9;
   localparam int CH_SER1_TX = 8;
   localparam int CH_SER1_RX = 7;
   localparam int CH_SER0_TX = 6;
   localparam int CH_SER0_RX = 5;
   localparam int CH_SER_ERR = 4;
   localparam int CH_WD_HALF = 3;
   localparam int CH_WD_MAX = 2;
   localparam int CH_EXT_PIN = 1;
   localparam int CH_BROWNOUT = 0;
endpackage
`default_nettype wire

// ===== hdl/cirq_prio_enc.sv
// highest-channel-wins index encoder for one processor line
// assumes its request vector is already pending, enabled and routed
`default_nettype none
module cirq_prio_enc (
   input wire logic [31:0] req,
   output logic [7:0] index
);
   // ------------------------------------------------------------
   // scan upward so the highest set channel is kept last
   // ------------------------------------------------------------
   always_comb begin
      index = cirq_pkg::INDEX_NONE;
      for (int i = 0; i < cirq_pkg::NUM_CH; i++) begin
         if (req[i]) begin
            index = 8'(i + 1);
         end
      end
   end
endmodule
`default_nettype wire

// ===== dv/cirq_periph_model.sv
// peripheral request sources facing the router's 32 request inputs
// assumes the bench names which channels fire; all on core_clk
`default_nettype none
module cirq_periph_model (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [31:0] fire,
   output logic [31:0] req
);
   // one-cycle event pulses, so only the sticky pending bit keeps them
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         req <= 32'h00000000;
      end else begin
         req <= fire;
      end
   end
endmodule
`default_nettype wire

// ===== dv/cirq_router_assertions.sv
// checker for the router's register port and processor lines
// assumes one core_clk domain and the synchronous active-low reset
`default_nettype none
module cirq_router_assertions (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [35:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic [3:0] wr_be,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic priv_mode,
   input wire logic [31:0] rd_data,
   input wire logic illegal_access,
   input wire logic normal_irq,
   input wire logic fast_irq,
   input wire logic irq_any
);
   logic [31:0] route_shadow;
   logic prot;
   logic mapped;
   assign prot = addr == cirq_pkg::IRQ_TYPE_ROUTING_ADDR
      || addr == cirq_pkg::REQUEST_MASK_ADDR;
   assign mapped = addr inside {cirq_pkg::NORMAL_IRQ_INDEX_ADDR,
      cirq_pkg::FAST_IRQ_INDEX_ADDR, cirq_pkg::IRQ_TYPE_ROUTING_ADDR,
      cirq_pkg::PENDING_REQUESTS_ADDR, cirq_pkg::REQUEST_MASK_ADDR,
      cirq_pkg::PENDING_CLEAR_ADDR};
   // --------------------------------------------
   // routing shadow: only privileged lanes land
   // --------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         route_shadow <= cirq_pkg::ROUTING_RESET;
      end else if (wr_stb && priv_mode && addr ==
         cirq_pkg::IRQ_TYPE_ROUTING_ADDR) begin
         for (int l = 0; l < 4; l++) begin
            if (wr_be[l]) begin
               route_shadow[8*l+:8] <= wr_data[8*l+:8];
            end
         end
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_user_write;
      wr_stb && !priv_mode && prot;
   endsequence
   sequence s_read_at(logic [35:0] a);
      rd_stb && addr == a;
   endsequence
   a_rd_idle_zero:
      assert property (!rd_stb |=> rd_data == cirq_pkg::READ_ZERO)
      else $error("read data not zero outside a read");
   a_user_write_trap:
      assert property (s_user_write |=> illegal_access)
      else $error("user write to protected register not flagged");
   a_trap_only_user:
      assert property (!(wr_stb && !priv_mode && prot) |=> !illegal_access)
      else $error("illegal access flagged without cause");
   a_normal_index_read:
      assert property (s_read_at(cirq_pkg::NORMAL_IRQ_INDEX_ADDR) |=>
         rd_data[31:8] == 24'h000000 && (rd_data != 0) == $past(normal_irq))
      else $error("normal index read disagrees with line");
   a_fast_index_read:
      assert property (s_read_at(cirq_pkg::FAST_IRQ_INDEX_ADDR) |=>
         rd_data[31:8] == 24'h000000 && (rd_data != 0) == $past(fast_irq))
      else $error("fast index read disagrees with line");
   a_route_readback:
      assert property (s_read_at(cirq_pkg::IRQ_TYPE_ROUTING_ADDR) |=>
         rd_data == $past(route_shadow))
      else $error("routing read differs from written lanes");
   a_unmapped_zero:
      assert property (rd_stb && !mapped |=> rd_data == 32'h00000000)
      else $error("unmapped read not zero");
   a_line_summary:
      assert property (normal_irq || fast_irq |-> irq_any)
      else $error("line high without summary");
endmodule
bind cirq_router cirq_router_assertions u_cirq_router_assertions (
   .core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
   .wr_be(wr_be), .wr_stb(wr_stb), .rd_stb(rd_stb),
   .priv_mode(priv_mode), .rd_data(rd_data),
   .illegal_access(illegal_access), .normal_irq(normal_irq),
   .fast_irq(fast_irq), .irq_any(irq_any)
);
`default_nettype wire

// ===== dv/cirq_router_tb.sv
// self-checking bench for the router, sources from the partner model
// assumes the plain register port with read data one cycle later
`default_nettype none
module cirq_router_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [35:0] NX = cirq_pkg::NORMAL_IRQ_INDEX_ADDR;
   localparam logic [35:0] FX = cirq_pkg::FAST_IRQ_INDEX_ADDR;
   localparam logic [35:0] RT = cirq_pkg::IRQ_TYPE_ROUTING_ADDR;
   localparam logic [35:0] PD = cirq_pkg::PENDING_REQUESTS_ADDR;
   localparam logic [35:0] MK = cirq_pkg::REQUEST_MASK_ADDR;
   localparam logic [35:0] CL = cirq_pkg::PENDING_CLEAR_ADDR;
   localparam logic [35:0] RST_ADDRS [5] = '{RT, MK, NX, FX, PD};
   typedef struct packed {
      logic [31:0] rt;
      logic [31:0] mk;
      logic [31:0] fi;
      logic [7:0] en;
      logic [7:0] ef;
   } cirq_row_t;
   localparam cirq_row_t ROWS [6] = '{
      '{32'h00000000, 32'hFFFFFFFF, 32'h00000001, 8'h01, 8'h00},
      '{32'h00000000, 32'hFFFFFFFF, 32'h40000001, 8'h1F, 8'h00},
      '{32'h00000000, 32'hFFFFFFFF, 32'h80000000, 8'h20, 8'h00},
      '{32'h80000000, 32'hFFFFFFFF, 32'h80000100, 8'h09, 8'h20},
      '{32'h00000000, 32'h7FFFFFFF, 32'h80000010, 8'h05, 8'h00},
      '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h00003030, 8'h00, 8'h0E}};
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [35:0] addr = 36'h000000000;
   logic [31:0] wr_data = 32'h00000000;
   logic [3:0] wr_be = 4'h0;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic priv_mode = 1'b0;
   logic [31:0] fire = 32'h00000000;
   logic [31:0] req;
   logic [31:0] rd_data;
   logic illegal_access;
   logic normal_irq;
   logic fast_irq;
   logic irq_any;
   logic [31:0] d;
   int fail_count = 0;
   int n_tests = 0;
   always #20 core_clk = ~core_clk;
   cirq_periph_model u_cirq_periph_model (.core_clk(core_clk),
      .rst_n(rst_n), .fire(fire), .req(req));
   cirq_router u_cirq_router (.core_clk(core_clk), .rst_n(rst_n),
      .addr(addr), .wr_data(wr_data), .wr_be(wr_be), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .priv_mode(priv_mode), .rd_data(rd_data),
      .illegal_access(illegal_access), .normal_irq(normal_irq),
      .fast_irq(fast_irq), .irq_any(irq_any),
      .external_fault_req(req[31]), .system_serial_req(req[30]),
      .pwm_gen0_req(req[29]), .pwm_gen1_req(req[28]),
      .pwm_gen2_req(req[27]), .pwm_gen3_req(req[26]),
      .fault_mux_req(req[25]), .converter_req(req[24]),
      .current_ctrl_clock_req(req[23]), .wide_timer_cmp0_req(req[22]),
      .wide_timer_cap0_req(req[21]), .wide_timer_cmp1_req(req[20]),
      .wide_timer_cap1_deadtime_req(req[19]),
      .wide_timer_overflow_req(req[18]),
      .narrow_timer_pwm0_req(req[17]), .narrow_timer_pwm1_req(req[16]),
      .narrow_timer_pwm2_req(req[15]), .narrow_timer_pwm3_req(req[14]),
      .front_end2_req(req[13]), .front_end1_req(req[12]),
      .front_end0_req(req[11]), .comparator_serial_req(req[10]),
      .pmbus_req(req[9]), .serial1_tx_req(req[8]),
      .serial1_rx_req(req[7]), .serial0_tx_req(req[6]),
      .serial0_rx_req(req[5]), .serial_err_req(req[4]),
      .watchdog_half_req(req[3]), .watchdog_max_req(req[2]),
      .external_pin_req(req[1]), .brownout_req(req[0]));
   // --------------------------------------------
   // bus, event and compare tasks
   // --------------------------------------------
   task automatic wr(input logic [35:0] a, input logic [31:0] v,
      input logic [3:0] be, input logic p);
      @(posedge core_clk);
      addr <= a;
      wr_data <= v;
      wr_be <= be;
      priv_mode <= p;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [35:0] a, output logic [31:0] v);
      @(posedge core_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1 v = rd_data;
   endtask
   task automatic fire_req(input logic [31:0] v);
      @(posedge core_clk);
      fire <= v;
      @(posedge core_clk);
      fire <= 32'h00000000;
      repeat (3) @(posedge core_clk);
   endtask
   task automatic chk(input string n, input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tally_and_finish;
      if (fail_count == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (ROWS[i]) begin
         wr(RT, ROWS[i].rt, 4'hF, 1'b1);
         wr(MK, ROWS[i].mk, 4'hF, 1'b1);
         wr(CL, 32'hFFFFFFFF, 4'hF, 1'b1);
         fire_req(ROWS[i].fi);
         rd(PD, d);
         chk("pending", d, ROWS[i].fi);
         rd(NX, d);
         chk("normal index", d, {24'h0, ROWS[i].en});
         rd(FX, d);
         chk("fast index", d, {24'h0, ROWS[i].ef});
         chk("normal line", 32'(normal_irq), 32'(|ROWS[i].en));
         chk("fast line", 32'(fast_irq), 32'(|ROWS[i].ef));
         d = ROWS[i].fi & ROWS[i].mk;
         chk("summary", 32'(irq_any), 32'(|d));
      end
      // --------------------------------------------
      // each input lands on its own channel bit
      // --------------------------------------------
      wr(RT, 32'h00000000, 4'hF, 1'b1);
      for (int c = 0; c < 32; c++) begin
         wr(CL, 32'hFFFFFFFF, 4'hF, 1'b1);
         fire_req(32'h00000001 << c);
         rd(PD, d);
         chk("chan bit", d, 32'h1 << c);
         rd(NX, d);
         chk("channel index", d, 32'(c + 1));
      end
      // ---------------------------------------------
      // read-only, unmapped and clearing cases
      // ---------------------------------------------
      wr(NX, 32'hFFFFFFFF, 4'hF, 1'b1);
      rd(NX, d);
      chk("index kept", d, 32'h00000020);
      rd(36'hFFFFFFF28, d);
      chk("unmapped", d, 32'h00000000);
      wr(CL, 32'h80000000, 4'hF, 1'b1);
      repeat (2) @(posedge core_clk);
      #1 chk("line drop", {30'h0, normal_irq, irq_any}, 32'h0);
      // ---------------------------------------------
      // second reset, then lanes and privilege
      // ---------------------------------------------
      // leave a pending fast request so the reset has work to undo
      wr(RT, 32'hFFFFFFFF, 4'hF, 1'b1);
      fire_req(32'h00000100);
      rst_n <= 1'b0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (RST_ADDRS[k]) begin
         rd(RST_ADDRS[k], d);
         chk("reset value", d, 32'h00000000);
      end
      wr(RT, 32'hA5A5A5A5, 4'h2, 1'b1);
      #1 chk("no trap", {31'h0, illegal_access}, 32'h0);
      wr(RT, 32'h12345678, 4'hF, 1'b0);
      #1 chk("trap", {31'h0, illegal_access}, 32'h1);
      rd(RT, d);
      chk("routing lanes", d, 32'h0000A500);
      chk("trap drop", {31'h0, illegal_access}, 32'h0);
      wr(MK, 32'hFFFFFFFF, 4'hF, 1'b0);
      #1 chk("mask trap", {31'h0, illegal_access}, 32'h1);
      rd(MK, d);
      chk("mask kept", d, 32'h00000000);
      // clearing with one lane enabled leaves the other lanes pending
      fire_req(32'h00000101);
      wr(CL, 32'hFFFFFFFF, 4'h2, 1'b1);
      rd(PD, d);
      chk("clear lanes", d, 32'h00000001);
      tally_and_finish();
   end
endmodule
`default_nettype wire
